// [logic/cse_pkg.sv]
// Shared constants and types for the compare/shift/store execution slice
package cse_pkg;
    // ***************************************************************
    // Instruction fields
    // ***************************************************************
    localparam int INSTR_W     = 32;
    localparam int OPC11_HI    = 31;
    localparam int OPC11_LO    = 21;
    localparam int MAJOR_HI    = 31;
    localparam int MAJOR_LO    = 26;
    localparam int RD_HI       = 25;
    localparam int RD_LO       = 21;
    localparam int IMM_HI      = 15;
    localparam int SHTYPE_HI   = 7;
    localparam int SHTYPE_LO   = 6;
    localparam int FUNC_HI     = 3;
    localparam int SHIMM_HI    = 5;
    localparam int OFFLO_HI    = 10;
    localparam int IMM_W       = 16;
    localparam int SHAMT_W     = 6;
    localparam int SHTYPE_W    = 2;
    localparam int REGIDX_W    = 5;

    // ***************************************************************
    // Opcodes
    // ***************************************************************
    localparam logic [10:0] OPC_LEUI = 11'h5e5;
    localparam logic [10:0] OPC_LTS  = 11'h72c;
    localparam logic [10:0] OPC_LTU  = 11'h724;
    localparam logic [10:0] OPC_LTSI = 11'h5ec;
    localparam logic [10:0] OPC_LTUI = 11'h5e4;
    localparam logic [10:0] OPC_NE   = 11'h721;
    localparam logic [10:0] OPC_NEI  = 11'h5e1;
    localparam logic [5:0]  MAJ_SHREG = 6'h38;
    localparam logic [5:0]  MAJ_SHIMM = 6'h2e;
    localparam logic [5:0]  MAJ_STH   = 6'h37;
    localparam logic [3:0]  FUNC_SH   = 4'h8;
    localparam logic [1:0]  SHT_SLL   = 2'h0;
    localparam logic [1:0]  SHT_SRA   = 2'h2;

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic RST_FLAG = 1'b0;

    typedef enum logic [1:0] {
        OP_NONE, OP_CMP, OP_SHIFT, OP_STORE
    } cse_op_type;
endpackage

// [logic/cse_shifter.sv]
// Combinational left-logical / right-arithmetic barrel shifter
`timescale 1ns/1ps
module cse_shifter #(
    parameter int XLEN = 64
) (
    input  wire logic [XLEN-1:0]              shiftSrc,
    input  wire logic [cse_pkg::SHAMT_W-1:0]  shiftAmt,
    input  wire logic [cse_pkg::SHTYPE_W-1:0] shiftType,
    output logic      [XLEN-1:0]              shiftResult
);
    import cse_pkg::*;

    // A 32-bit core drops count bit 5 so counts stay below the width
    localparam int AW = (XLEN == 64) ? 6 : 5;

    logic [AW-1:0] amt;

    // ***************************************************************
    // Shift
    // ***************************************************************
    always_comb begin
        amt = shiftAmt[AW-1:0];
        case (shiftType)
            SHT_SLL: shiftResult = shiftSrc << amt;
            SHT_SRA: shiftResult =
                $unsigned($signed(shiftSrc) >>> amt);
            default: shiftResult = '0;
        endcase
    end
endmodule // cse_shifter

// [logic/cse_exec.sv]
// Execution slice: set-flag compares, shifts and half-word store
//
// Contract
// - Unsigned less-or-equal immediate compare zero-extends the immediate and sets the flag when the source is not above it, else clears it.
// - Compares use all 64 source bits on a 64-bit core and only the low 32 bits on a 32-bit core.
// - Register less-than compares set the flag when the first is below the second, signed for 0x72c and unsigned for 0x724.
// - Immediate less-than compares set the flag when the source is below the immediate, sign-extended and signed for 0x5ec, zero-extended and unsigned for 0x5e4.
// - Register not-equal compare sets the flag when the two sources differ and clears it when they match.
// - Not-equal immediate compare sign-extends the immediate and sets the flag when the source differs from it.
// - Half-word store address is base plus sign-extended offset; the store may fault on TLB miss, page fault, bus error or alignment; only alignment is raised.
// - Half-word store writes only the low sixteen bits of the data source.
// - Register-count left shift moves the source left by the second source's count with zero fill into the destination.
// - A 32-bit core uses only the low five count bits, a 64-bit core all six.
// - Immediate left shift takes a six-bit immediate count, zero fills and writes the destination.
// - Register-count arithmetic right shift replicates the source sign into vacated high bits.
// - Immediate arithmetic right shift uses a six-bit immediate count with sign replication into the destination.
`timescale 1ns/1ps
module cse_exec #(
    parameter int XLEN = 64
) (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic                         issueValid,
    input  wire logic [cse_pkg::INSTR_W-1:0]  instr,
    input  wire logic [XLEN-1:0]              srcA,
    input  wire logic [XLEN-1:0]              srcB,
    output logic                              flagWe_ff,
    output logic                              compareFlag_ff,
    output logic                              rdWe_ff,
    output logic      [cse_pkg::REGIDX_W-1:0] rdIndex_ff,
    output logic      [XLEN-1:0]              rdData_ff,
    output logic                              storeValid_ff,
    output logic      [XLEN-1:0]              effectiveAddress_ff,
    output logic      [cse_pkg::IMM_W-1:0]    storeData_ff,
    output logic                              alignFault_ff,
    output logic                              illegalOp_ff
);
    import cse_pkg::*;

    // ***************************************************************
    // Decode
    // ***************************************************************
    logic [10:0]             opc11;
    logic [5:0]              major;
    logic [SHTYPE_W-1:0]     shType;
    logic [IMM_W-1:0]        storeOff;
    logic [XLEN-1:0]         immSext;
    logic [XLEN-1:0]         immZext;
    logic [XLEN-1:0]         offSext;
    logic [XLEN-1:0]         eaSum;
    logic [SHAMT_W-1:0]      shAmt;
    logic [XLEN-1:0]         shResult;
    logic                    cmpResult;
    logic                    shTypeOk;
    cse_op_type              opKind;

    // Field slicing; operands are already XLEN wide, so the
    // 32/64-bit split of compares falls out of the port width
    always_comb begin
        opc11    = instr[OPC11_HI:OPC11_LO];
        major    = instr[MAJOR_HI:MAJOR_LO];
        shType   = instr[SHTYPE_HI:SHTYPE_LO];
        shTypeOk = (shType == SHT_SLL) || (shType == SHT_SRA);
        immSext  = {{(XLEN-IMM_W){instr[IMM_HI]}}, instr[IMM_HI:0]};
        immZext  = {{(XLEN-IMM_W){1'b0}}, instr[IMM_HI:0]};
        // Split offset fields joined before extension
        storeOff = {instr[RD_HI:RD_LO], instr[OFFLO_HI:0]};
        offSext  = {{(XLEN-IMM_W){storeOff[IMM_W-1]}}, storeOff};
        eaSum    = srcA + offSext;
    end

    // Compare evaluation over the full operand width
    always_comb begin
        cmpResult = 1'b0;
        opKind    = OP_NONE;
        shAmt     = '0;
        case (opc11)
            OPC_LEUI: begin
                cmpResult = srcA <= immZext;
                opKind    = OP_CMP;
            end
            OPC_LTS: begin
                cmpResult = $signed(srcA) < $signed(srcB);
                opKind    = OP_CMP;
            end
            OPC_LTU: begin
                cmpResult = srcA < srcB;
                opKind    = OP_CMP;
            end
            OPC_LTSI: begin
                cmpResult = $signed(srcA) < $signed(immSext);
                opKind    = OP_CMP;
            end
            OPC_LTUI: begin
                cmpResult = srcA < immZext;
                opKind    = OP_CMP;
            end
            OPC_NE: begin
                cmpResult = srcA != srcB;
                opKind    = OP_CMP;
            end
            OPC_NEI: begin
                cmpResult = srcA != immSext;
                opKind    = OP_CMP;
            end
            default: begin
                cmpResult = 1'b0;
            end
        endcase
        // Shifts and the store are keyed on the 6-bit major opcode
        if (major == MAJ_SHREG && instr[FUNC_HI:0] == FUNC_SH
                && shTypeOk) begin
            opKind = OP_SHIFT;
            shAmt  = srcB[SHAMT_W-1:0];
        end else if (major == MAJ_SHIMM && shTypeOk) begin
            opKind = OP_SHIFT;
            shAmt  = instr[SHIMM_HI:0];
        end else if (major == MAJ_STH) begin
            opKind = OP_STORE;
        end
    end

    cse_shifter #(
        .XLEN        (XLEN)
    ) u_shifter (
        .shiftSrc    (srcA),
        .shiftAmt    (shAmt),
        .shiftType   (shType),
        .shiftResult (shResult)
    );

    // ***************************************************************
    // Result registers
    // ***************************************************************
    logic                nxt_flagWe;
    logic                nxt_compareFlag;
    logic                nxt_rdWe;
    logic [REGIDX_W-1:0] nxt_rdIndex;
    logic [XLEN-1:0]     nxt_rdData;
    logic                nxt_storeValid;
    logic [XLEN-1:0]     nxt_effectiveAddress;
    logic [IMM_W-1:0]    nxt_storeData;
    logic                nxt_alignFault;
    logic                nxt_illegalOp;

    // Strobes last one cycle; data holds so the flag stays readable
    always_comb begin
        nxt_flagWe           = 1'b0;
        nxt_compareFlag      = compareFlag_ff;
        nxt_rdWe             = 1'b0;
        nxt_rdIndex          = rdIndex_ff;
        nxt_rdData           = rdData_ff;
        nxt_storeValid       = 1'b0;
        nxt_effectiveAddress = effectiveAddress_ff;
        nxt_storeData        = storeData_ff;
        nxt_alignFault       = 1'b0;
        nxt_illegalOp        = 1'b0;
        if (issueValid) begin
            case (opKind)
                OP_CMP: begin
                    nxt_flagWe      = 1'b1;
                    nxt_compareFlag = cmpResult;
                end
                OP_SHIFT: begin
                    nxt_rdWe    = 1'b1;
                    nxt_rdIndex = instr[RD_HI:RD_LO];
                    nxt_rdData  = shResult;
                end
                OP_STORE: begin
                    nxt_storeValid       = 1'b1;
                    nxt_effectiveAddress = eaSum;
                    nxt_storeData        = srcB[IMM_W-1:0];
                    // Only the store can fault here
                    nxt_alignFault       = eaSum[0];
                end
                default: begin
                    nxt_illegalOp = 1'b1;
                end
            endcase
        end
    end

    // Plain registering, constants only under reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flagWe_ff           <= 1'b0;
            compareFlag_ff      <= RST_FLAG;
            rdWe_ff             <= 1'b0;
            rdIndex_ff          <= '0;
            rdData_ff           <= '0;
            storeValid_ff       <= 1'b0;
            effectiveAddress_ff <= '0;
            storeData_ff        <= '0;
            alignFault_ff       <= 1'b0;
            illegalOp_ff        <= 1'b0;
        end else begin
            flagWe_ff           <= nxt_flagWe;
            compareFlag_ff      <= nxt_compareFlag;
            rdWe_ff             <= nxt_rdWe;
            rdIndex_ff          <= nxt_rdIndex;
            rdData_ff           <= nxt_rdData;
            storeValid_ff       <= nxt_storeValid;
            effectiveAddress_ff <= nxt_effectiveAddress;
            storeData_ff        <= nxt_storeData;
            alignFault_ff       <= nxt_alignFault;
            illegalOp_ff        <= nxt_illegalOp;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_issue(logic [10:0] op);
        issueValid && instr[OPC11_HI:OPC11_LO] == op;
    endsequence

    sequence s_store;
        issueValid && instr[MAJOR_HI:MAJOR_LO] == MAJ_STH;
    endsequence

    property p_leui;
        s_issue(OPC_LEUI) |=> flagWe_ff && compareFlag_ff ==
            ($past(srcA) <= {{(XLEN-IMM_W){1'b0}}, $past(instr[15:0])});
    endproperty
    a_leui: assert property (p_leui) else $error("leui flag wrong");

    property p_lts;
        s_issue(OPC_LTS) |=> flagWe_ff && compareFlag_ff ==
            ($signed($past(srcA)) < $signed($past(srcB)));
    endproperty
    a_lts: assert property (p_lts) else $error("lts flag wrong");

    property p_ltui;
        s_issue(OPC_LTUI) |=> compareFlag_ff ==
            ($past(srcA) < {{(XLEN-IMM_W){1'b0}}, $past(instr[15:0])});
    endproperty
    a_ltui: assert property (p_ltui) else $error("ltui flag wrong");

    property p_ne;
        s_issue(OPC_NE) |=> compareFlag_ff == |($past(srcA) ^ $past(srcB));
    endproperty
    a_ne: assert property (p_ne) else $error("ne flag wrong");

    property p_nei;
        s_issue(OPC_NEI) |=> compareFlag_ff == ($past(srcA) !=
            {{(XLEN-IMM_W){$past(instr[15])}}, $past(instr[15:0])});
    endproperty
    a_nei: assert property (p_nei) else $error("nei flag wrong");

    property p_ea;
        s_store |=> storeValid_ff && !rdWe_ff && !flagWe_ff
            && effectiveAddress_ff == $past(srcA) + {{(XLEN-IMM_W){
            $past(instr[25])}}, $past(instr[25:21]), $past(instr[10:0])};
    endproperty
    a_ea: assert property (p_ea) else $error("store address wrong");

    property p_sdata;
        s_store |=> storeData_ff == $past(srcB[15:0])
            ##1 storeData_ff == $past(storeData_ff) || storeValid_ff;
    endproperty
    a_sdata: assert property (p_sdata) else $error("store data wrong");

    property p_shift;
        issueValid && major == MAJ_SHIMM && shType == SHT_SRA |=>
            rdWe_ff && rdData_ff == $unsigned($signed($past(srcA)) >>>
            $past(instr[SHIMM_HI:0]) % XLEN);
    endproperty
    a_shift: assert property (p_shift) else $error("srai result wrong");

    property p_noexc;
        alignFault_ff |-> storeValid_ff && effectiveAddress_ff[0];
    endproperty
    a_noexc: assert property (p_noexc) else $error("stray fault");
endmodule // cse_exec

// [dv/cse_lsu_model.sv]
// Load/store sink model that captures half-word store requests
`timescale 1ns/1ps
module cse_lsu_model #(
    parameter int XLEN = 64
) (
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            storeValid,
    input  wire logic [XLEN-1:0] effectiveAddress,
    input  wire logic [15:0]     storeData,
    input  wire logic            alignFault,
    output logic      [XLEN-1:0] lastAddr_ff,
    output logic      [15:0]     lastData_ff,
    output logic      [7:0]      count_ff
);
    // Faulted stores never reach memory, the exception cancels them
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lastAddr_ff <= '0;
            lastData_ff <= '0;
            count_ff    <= '0;
        end else if (storeValid && !alignFault) begin
            lastAddr_ff <= effectiveAddress;
            lastData_ff <= storeData;
            count_ff    <= count_ff + 8'h01;
        end
    end
endmodule // cse_lsu_model

// [dv/compare_shift_store_exec_tb_top.sv]
// Self-checking bench for the compare/shift/store execution slice
`timescale 1ns/1ps
module compare_shift_store_exec_tb_top;
    import cse_pkg::*;
    logic        ref_clk, reset_n, issueValid;
    logic [31:0] instr;
    logic [63:0] srcA, srcB, rdData, effAddr, lsuAddr;
    logic        flagWe, compareFlag, rdWe, storeValid, alignFault, illegalOp;
    logic [4:0]  rdIndex;
    logic [15:0] storeData, lsuData;
    logic [7:0]  lsuCount;
    int          mismatches = 0;
    int          comparisons = 0;

    cse_exec #(.XLEN(64)) uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .issueValid(issueValid),
        .instr(instr), .srcA(srcA), .srcB(srcB), .flagWe_ff(flagWe),
        .compareFlag_ff(compareFlag), .rdWe_ff(rdWe),
        .rdIndex_ff(rdIndex), .rdData_ff(rdData),
        .storeValid_ff(storeValid), .effectiveAddress_ff(effAddr),
        .storeData_ff(storeData), .alignFault_ff(alignFault),
        .illegalOp_ff(illegalOp));
    cse_lsu_model #(.XLEN(64)) lsu (
        .ref_clk(ref_clk), .reset_n(reset_n), .storeValid(storeValid),
        .effectiveAddress(effAddr), .storeData(storeData),
        .alignFault(alignFault), .lastAddr_ff(lsuAddr),
        .lastData_ff(lsuData), .count_ff(lsuCount));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Inputs move on the falling edge; result is read one cycle later
    task automatic issue(input logic [31:0] w, input logic [63:0] a, b);
        @(negedge ref_clk);
        issueValid = 1'b1;
        instr = w;
        srcA = a;
        srcB = b;
        @(negedge ref_clk);
        issueValid = 1'b0;
    endtask

    task automatic cmpTest(input logic [10:0] opc,
                           input logic [63:0] a, b, input logic exp);
        issue({opc, 5'h01, b[15:0]}, a, b);
        chk(flagWe, 1'b1);
        chk(compareFlag, exp);
        chk({rdWe, storeValid, illegalOp}, 3'h0);
    endtask

    function automatic logic [31:0] shR(input logic [1:0] t);
        return {MAJ_SHREG, 5'h03, 5'h01, 5'h02, 3'h0, t, 2'h0, FUNC_SH};
    endfunction

    function automatic logic [31:0] shI(input logic [1:0] t,
                                        input logic [5:0] l);
        return {MAJ_SHIMM, 5'h09, 5'h01, 8'h00, t, l};
    endfunction

    task automatic shTest(input logic [31:0] w, input logic [63:0] a, b, e);
        issue(w, a, b);
        chk(rdWe, 1'b1);
        chk(rdIndex, w[25:21]);
        chk(rdData, e);
        chk({flagWe, storeValid, illegalOp}, 3'h0);
    endtask

    task automatic stTest(input logic [15:0] off, input logic [63:0] base,
                          input logic [63:0] data, ea, input logic flt);
        issue({MAJ_STH, off[15:11], 5'h01, 5'h02, off[10:0]}, base, data);
        chk(storeValid, 1'b1);
        chk(effAddr, ea);
        chk(storeData, data[15:0]);
        chk(alignFault, flt);
        chk({rdWe, flagWe, illegalOp}, 3'h0);
        @(negedge ref_clk);
        if (!flt) begin
            chk(lsuAddr, ea);
            chk(lsuData, data[15:0]);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic testCompares;
        cmpTest(OPC_LEUI, 64'h10000, 64'h1ffff, 1'b0);
        cmpTest(OPC_LEUI, 64'hffff, 64'hffff, 1'b1);
        cmpTest(OPC_LEUI, 64'h1_0000_0000, 64'h0, 1'b0);
        cmpTest(OPC_LTS, '1, 64'h1, 1'b1);
        cmpTest(OPC_LTU, '1, 64'h1, 1'b0);
        cmpTest(OPC_LTU, 64'h1, '1, 1'b1);
        cmpTest(OPC_LTSI, 64'hffff_ffff_ffff_fffe, 64'hffff, 1'b1);
        cmpTest(OPC_LTSI, 64'h10, 64'hffff, 1'b0);
        cmpTest(OPC_LTUI, 64'hfffe, 64'hffff, 1'b1);
        cmpTest(OPC_LTUI, 64'h10000, 64'hffff, 1'b0);
        cmpTest(OPC_NE, 64'h5, 64'h5, 1'b0);
        cmpTest(OPC_NE, 64'h8000_0000_0000_0005, 64'h5, 1'b1);
        cmpTest(OPC_NEI, '1, 64'hffff, 1'b0);
        cmpTest(OPC_NEI, 64'hffff, 64'hffff, 1'b1);
        $display("test compares done");
    endtask

    // Flag was left set by the last compare and must survive shifts
    task automatic testShifts;
        shTest(shR(SHT_SLL), 64'h1, 64'd63, 64'h8000_0000_0000_0000);
        shTest(shR(SHT_SLL), 64'hff, 64'h44, 64'hff0);
        shTest(shR(SHT_SRA), 64'h8000_0000_0000_0000, 64'd4,
               64'hf800_0000_0000_0000);
        shTest(shR(SHT_SRA), 64'h4000_0000_0000_0000, 64'd62, 64'h1);
        shTest(shI(SHT_SLL, 6'd63), 64'h1, 64'h0,
               64'h8000_0000_0000_0000);
        shTest(shI(SHT_SLL, 6'h10), 64'h1234, 64'h0, 64'h1234_0000);
        shTest(shI(SHT_SRA, 6'd1), 64'h8000_0000_0000_0001, 64'h0,
               64'hc000_0000_0000_0000);
        shTest(shI(SHT_SRA, 6'd63), 64'h8000_0000_0000_0000, 64'h0, '1);
        chk(compareFlag, 1'b1);
        $display("test shifts done");
    endtask

    task automatic testStores;
        stTest(16'hfffe, 64'h1000, 64'hdead_beef_1234_5678, 64'hffe, 1'b0);
        stTest(16'h8001, 64'h10000, 64'h0, 64'h8001, 1'b1);
        stTest(16'h0842, 64'h0, 64'h1_abcd, 64'h842, 1'b0);
        chk(lsuCount, 8'h02);
        $display("test stores done");
    endtask

    task automatic testIllegal;
        issue(32'h0, 64'h1, 64'h2);
        chk(illegalOp, 1'b1);
        issue(shR(2'h1), 64'h1, 64'h2);
        chk(illegalOp, 1'b1);
        chk({flagWe, rdWe, storeValid}, 3'h0);
        $display("test illegal done");
    endtask

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Free-running core clock, 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Whole run is well under a hundred cycles; this cuts a hang
    initial begin
        #(25 * 2000);
        mismatches++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        issueValid = 1'b0;
        instr = '0;
        srcA = '0;
        srcB = '0;
        repeat (6) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        chk({compareFlag, flagWe, rdWe, storeValid, illegalOp}, 5'h00);
        testCompares();
        testShifts();
        testStores();
        testIllegal();
        conclude();
    end
endmodule // compare_shift_store_exec_tb_top
